// File: design/dsac_gen.v
// display port control generator: sync timing, async strobes, pixel fifo
`include "dsac_map.vh"

module dsac_fifo #(
    parameter W = 24,
    parameter D = 16,
    parameter AB = 4
) (
    input wire i_ref_clk,
    input wire i_rstn,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [W-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [W-1:0] o_out_data
);
    reg [W-1:0] mem [0:D-1];
    reg [AB-1:0] wp_q;
    reg [AB-1:0] rp_q;
    reg [AB:0] cnt_q;
    reg in_rdy_q;
    wire push = i_in_valid && in_rdy_q;
    wire pop = i_out_ready && (cnt_q != 0);
    wire [AB:0] cnt_d = cnt_q + {{AB{1'b0}}, push} - {{AB{1'b0}}, pop};
    // ready is registered so the top-level port comes straight from a flip-flop
    assign o_in_ready = in_rdy_q;
    assign o_out_valid = (cnt_q != 0);
    assign o_out_data = mem[rp_q];
    always @(posedge i_ref_clk) begin
        if (push) begin
            mem[wp_q] <= i_in_data;
        end
    end
    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            wp_q <= {AB{1'b0}};
            rp_q <= {AB{1'b0}};
            cnt_q <= {(AB+1){1'b0}};
            in_rdy_q <= 1'b0;
        end else begin
            in_rdy_q <= (cnt_d != D);
            if (push) begin
                wp_q <= (wp_q == D - 1) ? {AB{1'b0}} : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == D - 1) ? {AB{1'b0}} : rp_q + 1'b1;
            end
            cnt_q <= cnt_d;
        end
    end
endmodule // dsac_fifo

module dsac_gen #(
    parameter HW = 12,
    parameter VW = 12,
    parameter PW = 24,
    parameter DW = 24,
    parameter AW = 8,
    parameter FD = 16
) (
    input wire i_ref_clk,
    input wire i_rstn,
    input wire i_sync_en,
    input wire i_async_mode,
    input wire i_bt656_en,
    input wire i_clk_pol,
    input wire [HW-1:0] i_screen_width,
    input wire [HW-1:0] i_bgxp,
    input wire [HW-1:0] i_fw,
    input wire [VW-1:0] i_screen_height,
    input wire [VW-1:0] i_bgyp,
    input wire [VW-1:0] i_fh,
    input wire [6:0] i_sync_src,
    input wire [6:0] i_sync_pol,
    input wire [7*PW-1:0] i_sync_up,
    input wire [7*PW-1:0] i_sync_down,
    input wire [4:0] i_data_rot,
    input wire i_pix_valid,
    output wire o_pix_ready,
    input wire [DW-1:0] i_pix_data,
    input wire i_async_valid,
    output wire o_async_ready,
    input wire [DW-1:0] i_async_data,
    input wire [7:0] i_async_flags,
    input wire [AW-1:0] i_async_len,
    input wire [7*AW-1:0] i_async_up,
    input wire [7*AW-1:0] i_async_down,
    input wire [AW-1:0] i_cs_up,
    input wire [AW-1:0] i_cs_down,
    input wire i_pwm_en,
    input wire [7:0] i_pwm_duty,
    input wire i_frame_sync_in,
    output wire [DW-1:0] o_pixel_bus,
    output wire o_pixel_clock,
    output wire [6:0] o_sync_pin,
    output wire o_pixel_valid,
    output wire o_panel_select_0,
    output wire o_panel_select_1,
    output wire [6:0] o_async_pin,
    output wire o_underrun,
    output wire o_tear_sync
);
    localparam ST_IDLE = 1'b0;
    localparam ST_BUSY = 1'b1;

    function [DW-1:0] rot_map;
        input [DW-1:0] d;
        input [4:0] r;
        reg [2*DW-1:0] t;
        begin
            t = {d, d} << r;
            rot_map = t[2*DW-1:DW];
        end
    endfunction

    function in_win;
        input [PW-1:0] c;
        input [PW-1:0] up;
        input [PW-1:0] dn;
        begin
            in_win = (c >= up) && (c < dn);
        end
    endfunction

    function [7:0] bt_code;
        input [1:0] idx;
        input vb;
        input hb;
        begin
            case (idx)
                2'd0: bt_code = `DSAC_BT_PRE0;
                2'd1: bt_code = `DSAC_BT_PRE1;
                2'd2: bt_code = `DSAC_BT_PRE1;
                default: bt_code = {2'b10, vb, hb, vb ^ hb, hb, vb, vb ^ hb};
            endcase
        end
    endfunction

    reg phase_q;
    reg [HW-1:0] h_q;
    reg [VW-1:0] v_q;
    reg [7*PW-1:0] pcnt_q;
    reg [6:0] sync_q;
    reg pclk_q;
    reg pvalid_q;
    reg [DW-1:0] bus_q;
    reg under_q;
    reg ast_q;
    reg ardy_q;
    reg [AW-1:0] acnt_q;
    reg [7:0] aflag_q;
    reg [6:0] apin_q;
    reg cs0_q;
    reg cs1_q;
    reg [7:0] pwm_q;
    reg [2:0] fs_sync_q;
    reg tear_q;

    wire run = i_sync_en && !i_async_mode;
    wire tick = run && !phase_q;
    wire lsp = tick && (h_q == {HW{1'b0}});
    wire fsp = lsp && (v_q == {VW{1'b0}});
    wire hact = (h_q >= i_bgxp) && (h_q < i_bgxp + i_fw);
    wire vact = (v_q >= i_bgyp) && (v_q < i_bgyp + i_fh);
    wire active = hact && vact;
    wire [HW-1:0] sav_pos = i_bgxp - {{(HW-3){1'b0}}, `DSAC_BT_HDR_LEN};
    wire [HW-1:0] eav_pos = i_bgxp + i_fw;
    wire in_sav = (h_q >= sav_pos) && (h_q < i_bgxp);
    wire in_eav = (h_q >= eav_pos) && (h_q < eav_pos + {{(HW-3){1'b0}}, `DSAC_BT_HDR_LEN});
    wire [1:0] sav_idx = h_q[1:0] - sav_pos[1:0];
    wire [1:0] eav_idx = h_q[1:0] - eav_pos[1:0];
    wire [PW-1:0] line_half = {{(PW-HW-1){1'b0}}, i_screen_width, 1'b0};
    wire f_valid;
    wire [DW-1:0] f_data;
    wire f_pop = tick && active;
    wire a_take = i_async_valid && ardy_q;

    dsac_fifo #(.W(DW), .D(FD), .AB(4)) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_in_valid(i_pix_valid),
        .o_in_ready(o_pix_ready),
        .i_in_data(i_pix_data),
        .o_out_valid(f_valid),
        .i_out_ready(f_pop),
        .o_out_data(f_data)
    );

    // interface clock = two ref cycles, so one ref cycle is a half interface clock
    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            phase_q <= 1'b0;
            h_q <= {HW{1'b0}};
            v_q <= {VW{1'b0}};
            pclk_q <= 1'b0;
        end else if (run) begin
            phase_q <= ~phase_q;
            pclk_q <= i_clk_pol ^ phase_q;
            if (tick) begin
                if (h_q >= i_screen_width - 1'b1) begin
                    h_q <= {HW{1'b0}};
                    v_q <= (v_q >= i_screen_height - 1'b1) ? {VW{1'b0}} : v_q + 1'b1;
                end else begin
                    h_q <= h_q + 1'b1;
                end
            end
        end else begin
            phase_q <= 1'b0;
            pclk_q <= i_clk_pol;
        end
    end

    // per-pin half-clock counters restart at the chosen start point
    always @(posedge i_ref_clk) begin : sync_pins
        reg [PW-1:0] c;
        reg [PW-1:0] up;
        reg [PW-1:0] dn;
        integer k;
        c = {PW{1'b0}};
        up = {PW{1'b0}};
        dn = {PW{1'b0}};
        if (!i_rstn) begin
            pcnt_q <= {7*PW{1'b1}};
            sync_q <= 7'h00;
        end else begin
            for (k = 0; k < `DSAC_NSYNC; k = k + 1) begin
                c = pcnt_q[k*PW +: PW];
                up = i_sync_up[k*PW +: PW];
                dn = i_sync_down[k*PW +: PW];
                if (i_sync_src[k] == `DSAC_SRC_FRAME && dn < up + line_half) begin
                    dn = up + line_half;
                end
                if ((i_sync_src[k] == `DSAC_SRC_FRAME) ? fsp : lsp) begin
                    pcnt_q[k*PW +: PW] <= {PW{1'b0}};
                end else if (run && c != {PW{1'b1}}) begin
                    pcnt_q[k*PW +: PW] <= c + 1'b1;
                end
                sync_q[k] <= i_sync_pol[k] ^ (run && in_win(c, up, dn));
            end
        end
    end

    // pixel bus, data enable, embedded codes and async word launch
    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            bus_q <= `DSAC_BUS_RST;
            pvalid_q <= 1'b0;
            under_q <= 1'b0;
        end else if (i_async_mode) begin
            pvalid_q <= 1'b0;
            if (a_take) begin
                bus_q <= rot_map(i_async_data, i_data_rot);
            end
        end else if (tick) begin
            pvalid_q <= active;
            if (active && !f_valid) begin
                under_q <= 1'b1;
            end
            if (i_bt656_en) begin
                if (active) begin
                    bus_q <= {{(DW-8){1'b0}}, f_data[7:0]};
                end else if (in_sav) begin
                    bus_q <= {{(DW-8){1'b0}}, bt_code(sav_idx, !vact, 1'b0)};
                end else if (in_eav) begin
                    bus_q <= {{(DW-8){1'b0}}, bt_code(eav_idx, !vact, 1'b1)};
                end else begin
                    bus_q <= {{(DW-8){1'b0}}, h_q[0] ? `DSAC_BT_BLANK_Y : `DSAC_BT_BLANK_C};
                end
            end else begin
                bus_q <= active ? rot_map(f_valid ? f_data : {DW{1'b0}}, i_data_rot)
                                : `DSAC_BUS_RST;
            end
        end
    end

    // async engine: each accepted word is a fresh start point for its strobes
    always @(posedge i_ref_clk) begin : async_gen
        reg [AW-1:0] u;
        reg [AW-1:0] d;
        integer k;
        u = {AW{1'b0}};
        d = {AW{1'b0}};
        if (!i_rstn) begin
            ast_q <= ST_IDLE;
            ardy_q <= 1'b0;
            acnt_q <= {AW{1'b0}};
            aflag_q <= 8'h00;
            apin_q <= 7'h00;
            cs0_q <= 1'b0;
            cs1_q <= 1'b0;
            pwm_q <= 8'h00;
        end else begin
            pwm_q <= pwm_q + 1'b1;
            case (ast_q)
                ST_IDLE: begin
                    if (a_take) begin
                        ast_q <= ST_BUSY;
                        acnt_q <= {AW{1'b0}};
                        aflag_q <= i_async_flags;
                        ardy_q <= 1'b0;
                    end else begin
                        ardy_q <= i_async_mode;
                    end
                end
                ST_BUSY: begin
                    if (acnt_q + 1'b1 >= i_async_len) begin
                        ast_q <= ST_IDLE;
                        ardy_q <= i_async_mode;
                    end else begin
                        acnt_q <= acnt_q + 1'b1;
                    end
                end
                default: begin
                    ast_q <= ST_IDLE;
                end
            endcase
            for (k = 0; k < `DSAC_NASYNC; k = k + 1) begin
                u = i_async_up[k*AW +: AW];
                d = i_async_down[k*AW +: AW];
                apin_q[k] <= (ast_q == ST_BUSY) && aflag_q[k]
                    && (acnt_q >= u) && (acnt_q < d);
            end
            cs0_q <= (ast_q == ST_BUSY) && !aflag_q[`DSAC_AF_SEL]
                && (acnt_q >= i_cs_up) && (acnt_q < i_cs_down);
            if (i_pwm_en) begin
                cs1_q <= (pwm_q < i_pwm_duty);
            end else begin
                cs1_q <= (ast_q == ST_BUSY) && aflag_q[`DSAC_AF_SEL]
                    && (acnt_q >= i_cs_up) && (acnt_q < i_cs_down);
            end
        end
    end

    // returned frame sync from a smart panel, synchronised then edge detected
    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            fs_sync_q <= 3'h0;
            tear_q <= 1'b0;
        end else begin
            fs_sync_q <= {fs_sync_q[1:0], i_frame_sync_in};
            tear_q <= fs_sync_q[1] && !fs_sync_q[2];
        end
    end

    assign o_pixel_bus = bus_q;
    assign o_pixel_clock = pclk_q;
    assign o_sync_pin = sync_q;
    assign o_pixel_valid = pvalid_q;
    assign o_panel_select_0 = cs0_q;
    assign o_panel_select_1 = cs1_q;
    assign o_async_pin = apin_q;
    assign o_async_ready = ardy_q;
    assign o_underrun = under_q;
    assign o_tear_sync = tear_q;
endmodule // dsac_gen

// File: design/dsac_map.vh
// constants for the display sync/async control generator
`ifndef DSAC_MAP_VH
`define DSAC_MAP_VH
`define DSAC_REF_NS 40
`define DSAC_REF_HZ 25000000
`define DSAC_IFACE_DIV 2
`define DSAC_NSYNC 7
`define DSAC_NASYNC 7
`define DSAC_AF_SEL 7
`define DSAC_SRC_FRAME 1'b1
`define DSAC_BT_PRE0 8'hFF
`define DSAC_BT_PRE1 8'h00
`define DSAC_BT_BLANK_Y 8'h10
`define DSAC_BT_BLANK_C 8'h80
`define DSAC_BT_HDR_LEN 3'h4
`define DSAC_BUS_RST 24'h000000
`endif

// File: verification/dsac_gen_sva.sv
// assertion checker for the display port control generator
module dsac_gen_sva #(
    parameter DW = 24
) (
    input wire i_ref_clk,
    input wire i_rstn,
    input wire i_sync_en,
    input wire i_async_mode,
    input wire i_bt656_en,
    input wire [4:0] i_data_rot,
    input wire i_async_valid,
    input wire o_async_ready,
    input wire [DW-1:0] i_async_data,
    input wire [7:0] i_async_flags,
    input wire i_pwm_en,
    input wire i_frame_sync_in,
    input wire [DW-1:0] o_pixel_bus,
    input wire o_pixel_clock,
    input wire o_pixel_valid,
    input wire o_panel_select_0,
    input wire o_panel_select_1,
    input wire [6:0] o_async_pin,
    input wire o_underrun,
    input wire o_tear_sync
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] up_q;
    wire run = i_sync_en & ~i_async_mode;
    wire take = i_async_valid & o_async_ready & i_async_mode;
    // cycles since reset release, keeps past values from the reset out of view
    always @(posedge i_ref_clk) begin
        if (!i_rstn) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    pclk_toggle_a: assert property (run && $past(run) && up_q == 2'h3
        |=> o_pixel_clock != $past(o_pixel_clock)) else $error("pixel clock stalled");
    busy_ready_a: assert property (take |=> !o_async_ready)
        else $error("ready stayed high after accept");
    word_bus_a: assert property (take && i_data_rot == 5'h00
        |=> o_pixel_bus == $past(i_async_data)) else $error("async word not on bus");
    quiet_pins_a: assert property (take && i_async_flags[6:0] == 7'h00
        |=> ##1 (o_async_pin == 7'h00) [*3]) else $error("unflagged async pin moved");
    one_select_a: assert property (!i_pwm_en |-> !(o_panel_select_0 && o_panel_select_1))
        else $error("both panel selects active");
    tear_delay_a: assert property ($rose(i_frame_sync_in) && up_q == 2'h3
        |-> ##3 o_tear_sync) else $error("tear pulse missing");
    tear_pulse_a: assert property (o_tear_sync |=> !o_tear_sync)
        else $error("tear pulse too long");
    underrun_hold_a: assert property (o_underrun |=> o_underrun)
        else $error("underrun flag dropped");
    blank_zero_a: assert property (run [*3] ##0 (!o_pixel_valid && !i_bt656_en)
        |-> o_pixel_bus == {DW{1'b0}}) else $error("bus not cleared in blanking");
    valid_pair_a: assert property (run && $rose(o_pixel_valid) |=> o_pixel_valid)
        else $error("pixel shorter than an interface clock");
endmodule // dsac_gen_sva

bind dsac_gen dsac_gen_sva #(.DW(DW)) chk_u (.i_ref_clk, .i_rstn, .i_sync_en, .i_async_mode,
    .i_bt656_en, .i_data_rot, .i_async_valid, .o_async_ready, .i_async_data, .i_async_flags,
    .i_pwm_en, .i_frame_sync_in, .o_pixel_bus, .o_pixel_clock, .o_pixel_valid,
    .o_panel_select_0, .o_panel_select_1, .o_async_pin, .o_underrun, .o_tear_sync);

// File: verification/dsac_panel_model.sv
// panel model: latches valid pixels and returns a frame sync on request
module dsac_panel_model (
    input wire i_ref_clk,
    input wire i_pixel_valid,
    input wire [23:0] i_pixel_bus,
    input wire i_te_req,
    output wire o_frame_sync
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] words [0:31];
    int n_words = 0;
    int te_left = 0;
    logic half = 1'b0;
    // each pixel stands two cycles, take it once
    always @(posedge i_ref_clk) begin
        half <= i_pixel_valid & ~half;
        if (i_pixel_valid && !half) begin
            words[n_words & 31] <= i_pixel_bus;
            n_words <= n_words + 1;
        end
        if (i_te_req) te_left <= 6;
        else if (te_left > 0) te_left <= te_left - 1;
    end
    assign o_frame_sync = te_left > 0;
endmodule // dsac_panel_model

// File: verification/test_dsac_gen.sv
// self-checking testbench for the display port control generator
module test_dsac_gen;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 1'b0, i_rstn = 1'b0, i_sync_en = 1'b0, i_async_mode = 1'b0;
    logic i_bt656_en = 1'b0, i_clk_pol = 1'b0, i_pix_valid = 1'b0, i_async_valid = 1'b0;
    logic i_pwm_en = 1'b0, te_req = 1'b0;
    logic [11:0] i_screen_width = 12'h008, i_bgxp = 12'h004, i_fw = 12'h002;
    logic [11:0] i_screen_height = 12'h004, i_bgyp = 12'h001, i_fh = 12'h002;
    logic [6:0] i_sync_src = 7'h02, i_sync_pol = 7'h00;
    logic [167:0] i_sync_up = 168'h0, i_sync_down = 168'h4;
    logic [4:0] i_data_rot = 5'h00;
    logic [23:0] i_pix_data = 24'h0, i_async_data = 24'h0;
    logic [7:0] i_async_flags = 8'h00, i_async_len = 8'h08, i_cs_up = 8'h00, i_cs_down = 8'h06;
    logic [55:0] i_async_up = {7{8'h01}}, i_async_down = {7{8'h05}};
    logic [7:0] i_pwm_duty = 8'h40;
    wire i_frame_sync_in, o_pix_ready, o_async_ready, o_pixel_clock, o_pixel_valid;
    wire o_panel_select_0, o_panel_select_1, o_underrun, o_tear_sync;
    wire [23:0] o_pixel_bus;
    wire [6:0] o_sync_pin, o_async_pin;
    int mismatches = 0, samples_checked = 0;

    dsac_gen dut_u (.i_ref_clk, .i_rstn, .i_sync_en, .i_async_mode, .i_bt656_en, .i_clk_pol,
        .i_screen_width, .i_bgxp, .i_fw, .i_screen_height, .i_bgyp, .i_fh, .i_sync_src,
        .i_sync_pol, .i_sync_up, .i_sync_down, .i_data_rot, .i_pix_valid, .o_pix_ready,
        .i_pix_data, .i_async_valid, .o_async_ready, .i_async_data, .i_async_flags,
        .i_async_len, .i_async_up, .i_async_down, .i_cs_up, .i_cs_down, .i_pwm_en, .i_pwm_duty,
        .i_frame_sync_in, .o_pixel_bus, .o_pixel_clock, .o_sync_pin, .o_pixel_valid,
        .o_panel_select_0, .o_panel_select_1, .o_async_pin, .o_underrun, .o_tear_sync);
    dsac_panel_model panel_u (.i_ref_clk, .i_pixel_valid(o_pixel_valid),
        .i_pixel_bus(o_pixel_bus), .i_te_req(te_req), .o_frame_sync(i_frame_sync_in));

    always #20 i_ref_clk = ~i_ref_clk;

    task automatic step(int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic chk_word(logic [23:0] got, logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_count(int got, int exp);
        samples_checked++;
        if (got != exp) begin
            mismatches++;
            $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask

    // high time and full period of a sync pin, in reference cycles
    task automatic pulse(int k, int lim, output int w, output int p);
        int t;
        t = 0;
        w = 0;
        p = 0;
        while (o_sync_pin[k] !== 1'b1 && t < lim) begin
            step(1);
            t++;
        end
        while (o_sync_pin[k] === 1'b1 && w < lim) begin
            step(1);
            w++;
        end
        while (o_sync_pin[k] === 1'b0 && p < lim) begin
            step(1);
            p++;
        end
        p += w;
    endtask

    task automatic t_stream();
        int n, w, p;
        n = 0;
        i_pix_valid = 1'b1;
        while (o_pix_ready === 1'b1 && n < 40) begin
            i_pix_data = 24'hA50000 + 24'(n);
            step(1);
            n++;
        end
        i_pix_valid = 1'b0;
        chk_count(n, 16);
        i_sync_en = 1'b1;
        pulse(0, 80, w, p);
        chk_count(w, 4);
        chk_count(p, 16);
        pulse(1, 80, w, p);
        chk_count(w, 16);
        chk_count(p, 64);
        step(256);
        for (int i = 0; i < 16; i++) chk_word(panel_u.words[i], 24'hA50000 + 24'(i));
        chk_word({23'h0, o_underrun}, 24'h1);
        i_sync_en = 1'b0;
        i_clk_pol = 1'b1;
        step(3);
        chk_word({23'h0, o_pixel_clock}, 24'h1);
        $display("stream test done");
    endtask

    // embedded codes: end-of-active header of an active line, then blanking fill
    task automatic t_bt656();
        int t;
        t = 0;
        i_screen_width = 12'h00C;
        i_bt656_en = 1'b1;
        i_sync_en = 1'b1;
        while (o_pixel_valid !== 1'b1 && t < 200) begin
            step(1);
            t++;
        end
        while (o_pixel_bus[7:0] !== 8'hFF && t < 200) begin
            step(1);
            t++;
        end
        chk_count(int'(t < 200), 1);
        step(2);
        chk_word(o_pixel_bus, 24'h000000);
        step(2);
        chk_word(o_pixel_bus, 24'h000000);
        step(2);
        chk_word(o_pixel_bus, 24'h00009D);
        step(2);
        chk_word(o_pixel_bus, 24'h000080);
        i_sync_en = 1'b0;
        i_bt656_en = 1'b0;
        i_screen_width = 12'h008;
        step(2);
        $display("bt656 test done");
    endtask

    task automatic send(logic [23:0] d, logic [7:0] f);
        int t;
        t = 0;
        i_async_data = d;
        i_async_flags = f;
        i_async_valid = 1'b1;
        while (o_async_ready !== 1'b1 && t < 50) begin
            step(1);
            t++;
        end
        step(1);
        i_async_valid = 1'b0;
        chk_count(int'(t < 50), 1);
    endtask

    task automatic t_async();
        i_async_mode = 1'b1;
        step(2);
        for (int k = 0; k < 8; k++) begin
            send(24'h5A0000 + 24'(k), 8'(1 << k));
            step(3);
            chk_word(o_pixel_bus, 24'h5A0000 + 24'(k));
            chk_word({17'h0, o_async_pin}, 24'((k < 7) ? (1 << k) : 0));
            chk_word({22'h0, o_panel_select_1, o_panel_select_0}, (k == 7) ? 24'h2 : 24'h1);
        end
        $display("async test done");
    endtask

    task automatic t_pwm();
        int w;
        i_pwm_en = 1'b1;
        step(2);
        w = 0;
        for (int i = 0; i < 256; i++) begin
            w += int'(o_panel_select_1 === 1'b1);
            step(1);
        end
        chk_count(w, 64);
        i_pwm_en = 1'b0;
        $display("pwm test done");
    endtask

    task automatic t_tear();
        int w;
        w = 0;
        te_req = 1'b1;
        step(1);
        te_req = 1'b0;
        for (int i = 0; i < 12; i++) begin
            w += int'(o_tear_sync === 1'b1);
            step(1);
        end
        chk_count(w, 1);
        $display("tear test done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        step(8);
        i_rstn = 1'b1;
        step(2);
        t_stream();
        t_bt656();
        t_async();
        t_pwm();
        t_tear();
        give_verdict();
    end

    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end
endmodule // test_dsac_gen
